// File: bench/dic_classifier_chk.sv
`timescale 1ns/1ps
module dic_classifier_chk (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic decode_valid_i,
	input wire logic ready_o,
	input wire logic valid_o,
	input wire logic illegal_o,
	input wire dic_pkg::dic_class_t cls_o,
	input wire logic [2:0] cycles_o,
	input wire logic repeatable_o,
	input wire logic [1:0] slots_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic slot_o
);
	// ******************************
	// Run-length counters
	// ******************************
	logic [3:0] busy_run_ff;
	logic [3:0] nxt_busy_run;
	logic [3:0] slot_run_ff;
	logic [3:0] nxt_slot_run;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	always_comb begin
		nxt_busy_run = busy_o ? busy_run_ff + 4'h1 : 4'h0;
		nxt_slot_run = slot_o ? slot_run_ff + 4'h1 : 4'h0;
	end

	always_ff @(posedge clk_sys_i) begin
		busy_run_ff <= nxt_busy_run;
		slot_run_ff <= nxt_slot_run;
	end

	take_answer_a: assert property (
		decode_valid_i && ready_o |=> valid_o) else $error("no answer");
	no_take_a: assert property (
		!ready_o |=> !valid_o) else $error("answer while busy");
	busy_len_a: assert property (
		$fell(busy_o) |-> busy_run_ff == {1'b0, cycles_o})
		else $error("busy length differs from cycle count");
	slot_len_a: assert property (
		$fell(slot_o) |-> slot_run_ff == {2'h0, slots_o})
		else $error("slot length differs from slot count");
	done_slot_a: assert property (
		$fell(busy_o) |-> done_o && (slot_o == (slots_o != 2'h0)))
		else $error("done or slot start wrong");
	plain_jump_a: assert property (
		valid_o && !illegal_o && cls_o inside {dic_pkg::CLS_VIII,
		dic_pkg::CLS_X} |-> cycles_o == 3'h4 && slots_o == 2'h0 &&
		!repeatable_o) else $error("plain jump attributes wrong");
	delay_jump_a: assert property (
		valid_o && !illegal_o && cls_o inside {dic_pkg::CLS_IX,
		dic_pkg::CLS_XI} |-> cycles_o == 3'h2 && slots_o == 2'h2 &&
		!repeatable_o) else $error("delayed jump attributes wrong");
	illegal_idle_a: assert property (
		valid_o && illegal_o |-> !busy_o && ready_o)
		else $error("illegal form started work");
	done_pulse_a: assert property (
		done_o |=> !done_o) else $error("done longer than one cycle");
endmodule

bind dic_classifier dic_classifier_chk dic_classifier_chk_i (
	.clk_sys_i, .reset_n_i, .decode_valid_i, .ready_o, .valid_o,
	.illegal_o, .cls_o, .cycles_o, .repeatable_o, .slots_o, .busy_o,
	.done_o, .slot_o);

// File: bench/dic_classifier_test.sv
`timescale 1ns/1ps
module dic_classifier_test;
	logic clk_sys_i;
	logic reset_n_i;
	logic decode_valid_i;
	dic_pkg::dic_form_t form_i;
	logic ready_o, valid_o, illegal_o, repeatable_o, protected_o;
	logic busy_o, done_o, slot_o;
	dic_pkg::dic_class_t cls_o;
	logic [1:0] words_o;
	logic [2:0] cycles_o;
	logic [1:0] slots_o;
	dic_pkg::dic_mem_t mem_kind_o;
	int error_cnt = 0;
	int checks_done = 0;
	int cyc = 0;

	dic_classifier dic_classifier_i (.clk_sys_i, .reset_n_i,
		.decode_valid_i, .form_i, .ready_o, .valid_o, .illegal_o, .cls_o,
		.words_o, .cycles_o, .repeatable_o, .slots_o, .protected_o,
		.mem_kind_o, .busy_o, .done_o, .slot_o);

	initial begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	// Longest run is well under a thousand cycles
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			results();
		end
	end

	// ******************************
	// Shared tasks
	// ******************************
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle_wait();
		int n;
		n = 0;
		while (ready_o !== 1'b1 && n < 20) begin
			@(negedge clk_sys_i);
			n++;
		end
	endtask

	task automatic run(input dic_pkg::dic_form_t f, input int w,
		input int c, input int r, input int s, input int p);
		int b;
		int sl;
		idle_wait();
		form_i = f;
		decode_valid_i = 1'b1;
		@(negedge clk_sys_i);
		decode_valid_i = 1'b0;
		check("valid", 8'(valid_o), 8'h01);
		check("illegal", 8'(illegal_o), 8'h00);
		check("words", 8'(words_o), 8'(w));
		check("cycle out", 8'(cycles_o), 8'(c));
		check("slot out", 8'(slots_o), 8'(s));
		check("repeat", 8'(repeatable_o), 8'(r));
		check("protect", 8'(protected_o), 8'(p));
		b = 0;
		while (busy_o === 1'b1 && b < 8) begin
			b++;
			@(negedge clk_sys_i);
		end
		check("cycles", 8'(b), 8'(c));
		check("done", 8'(done_o), 8'h01);
		sl = 0;
		while (slot_o === 1'b1 && sl < 8) begin
			sl++;
			@(negedge clk_sys_i);
		end
		check("slots", 8'(sl), 8'(s));
		check("ready", 8'(ready_o), 8'h01);
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic refused();
		idle_wait();
		form_i = dic_pkg::F_BRANCH;
		decode_valid_i = 1'b1;
		@(negedge clk_sys_i);
		form_i = dic_pkg::F_NO_OP;
		@(negedge clk_sys_i);
		check("valid", 8'(valid_o), 8'h00);
		check("words", 8'(words_o), 8'h02);
		decode_valid_i = 1'b0;
	endtask

	// Access kind and class follow the operand rules
	task automatic mem_kinds();
		run(dic_pkg::F_ABS_ACC, 1, 1, 1, 0, 0);
		check("mem", 8'(mem_kind_o), 8'(dic_pkg::MEM_NONE));
		check("class", 8'(cls_o), 8'(dic_pkg::CLS_I));
		run(dic_pkg::F_ADD_MEM, 1, 1, 1, 0, 0);
		check("mem", 8'(mem_kind_o), 8'(dic_pkg::MEM_READ));
		check("class", 8'(cls_o), 8'(dic_pkg::CLS_IIA));
		run(dic_pkg::F_REPEAT_BLOCK, 2, 2, 0, 0, 0);
		check("mem", 8'(mem_kind_o), 8'(dic_pkg::MEM_NONE));
		check("class", 8'(cls_o), 8'(dic_pkg::CLS_III));
		run(dic_pkg::F_STORE_STATUS, 1, 1, 1, 0, 0);
		check("mem", 8'(mem_kind_o), 8'(dic_pkg::MEM_WRITE));
		check("class", 8'(cls_o), 8'(dic_pkg::CLS_IVA));
	endtask

	// One unknown code issued twice back to back, attributes must hold
	task automatic bad_form();
		idle_wait();
		form_i = dic_pkg::dic_form_t'(7'h7F);
		decode_valid_i = 1'b1;
		repeat (2) begin
			@(negedge clk_sys_i);
			check("valid", 8'(valid_o), 8'h01);
			check("illegal", 8'(illegal_o), 8'h01);
			check("busy", 8'(busy_o), 8'h00);
			check("ready", 8'(ready_o), 8'h01);
			check("words", 8'(words_o), 8'h02);
		end
		decode_valid_i = 1'b0;
	endtask

	task automatic results();
		$display("Checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	initial begin
		reset_n_i = 1'b0;
		decode_valid_i = 1'b0;
		form_i = dic_pkg::F_NO_OP;
		repeat (12) @(negedge clk_sys_i);
		check("ready", 8'(ready_o), 8'h00);
		check("busy", 8'(busy_o), 8'h00);
		check("words", 8'(words_o), 8'h00);
		reset_n_i = 1'b1;
		mem_kinds();
		run(dic_pkg::F_ADD_SHORT_IMM, 1, 1, 0, 0, 0);
		run(dic_pkg::F_CONDITIONAL_EXECUTE, 1, 1, 0, 0, 0);
		run(dic_pkg::F_ACC_STORE_TO_MAPPED_REG, 1, 1, 1, 0, 0);
		run(dic_pkg::F_TEMP_LOAD_MOVE, 1, 1, 1, 0, 0);
		run(dic_pkg::F_COMPARE_PARALLEL_LOGIC_LONG, 2, 2, 1, 0, 0);
		run(dic_pkg::F_STORE_LONG_IMMEDIATE, 2, 2, 0, 0, 0);
		run(dic_pkg::F_CALL_CONDITIONAL, 2, 4, 0, 0, 0);
		run(dic_pkg::F_BRANCH_DLY, 2, 2, 0, 2, 0);
		run(dic_pkg::F_RETURN_FROM_INT, 1, 4, 0, 0, 0);
		run(dic_pkg::F_RETURN_COND_DELAYED, 1, 2, 0, 2, 0);
		run(dic_pkg::F_BLOCK_MOVE_DATA_DATA_LONG, 2, 3, 1, 0, 0);
		run(dic_pkg::F_BLOCK_MOVE_DATA_DATA, 1, 2, 1, 0, 0);
		run(dic_pkg::F_BLOCK_MOVE_PROG_DATA_LONG, 2, 3, 1, 0, 0);
		run(dic_pkg::F_BLOCK_MOVE_DATA_PROG, 1, 2, 1, 0, 0);
		run(dic_pkg::F_TABLE_WRITE_OP, 1, 3, 1, 0, 0);
		run(dic_pkg::F_MULT_ACCUM_TWO_WORD, 2, 3, 1, 0, 0);
		run(dic_pkg::F_MULT_ACCUM_DYN_ADDR, 1, 2, 1, 0, 0);
		run(dic_pkg::F_MULT_ACCUM_MOVE_DYN_ADDR, 1, 2, 1, 0, 0);
		run(dic_pkg::F_MAPPED_REG_STORE_LONG, 2, 2, 1, 0, 0);
		run(dic_pkg::F_PORT_OUT, 2, 3, 1, 0, 0);
		run(dic_pkg::F_PORT_IN, 2, 2, 1, 0, 0);
		run(dic_pkg::F_STATUS_LOAD, 1, 2, 1, 0, 1);
		run(dic_pkg::F_PAGE_POINTER_LOAD_IMM, 1, 2, 0, 0, 1);
		run(dic_pkg::F_REPEAT_NEXT_IMM, 1, 2, 0, 0, 1);
		refused();
		bad_form();
		results();
	end
endmodule

// File: core/dic_attr_if.sv
`timescale 1ns/1ps
interface dic_attr_if;
	dic_pkg::dic_class_t cls;
	dic_pkg::dic_attr_t attr;

	modport rom (
		input cls,
		output attr
	);

	modport user (
		output cls,
		input attr
	);
endinterface

// File: core/dic_class_rom.sv
`timescale 1ns/1ps
module dic_class_rom (
	dic_attr_if.rom port_if
);
	// ****************************************************************
	// Class attribute table
	// ****************************************************************
	dic_pkg::dic_attr_t a;

	always_comb begin
		a = dic_pkg::ATTR_RESET;
		a.words = dic_pkg::WORDS_ONE;
		a.cycles = dic_pkg::CYC_ONE;
		a.repeatable = 1'b1;
		a.slots = dic_pkg::SLOTS_NONE;
		a.protect = 1'b0;
		a.mem = dic_pkg::MEM_NONE;
		case (port_if.cls)
			dic_pkg::CLS_I: begin
				a.mem = dic_pkg::MEM_NONE;
			end
			dic_pkg::CLS_IIA: begin
				a.mem = dic_pkg::MEM_READ;
			end
			dic_pkg::CLS_IIB: begin
				a.mem = dic_pkg::MEM_MMR_RD;
			end
			dic_pkg::CLS_IVB: begin
				a.mem = dic_pkg::MEM_MMR_WR;
			end
			dic_pkg::CLS_III: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_TWO;
				a.repeatable = 1'b0;
			end
			dic_pkg::CLS_IVA: begin
				a.mem = dic_pkg::MEM_WRITE;
			end
			dic_pkg::CLS_V: begin
				a.mem = dic_pkg::MEM_RMW;
			end
			dic_pkg::CLS_VI: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_TWO;
				a.mem = dic_pkg::MEM_RMW;
			end
			dic_pkg::CLS_VIIA: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_TWO;
				a.mem = dic_pkg::MEM_READ;
			end
			dic_pkg::CLS_VIIB: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_TWO;
				a.repeatable = 1'b0;
				a.mem = dic_pkg::MEM_WRITE;
			end
			dic_pkg::CLS_VIII, dic_pkg::CLS_IX: begin
				a.words = dic_pkg::WORDS_TWO;
				a.repeatable = 1'b0;
				a.mem = dic_pkg::MEM_PC;
				if (port_if.cls == dic_pkg::CLS_IX) begin
					a.cycles = dic_pkg::CYC_TWO;
					a.slots = dic_pkg::SLOTS_TWO;
				end else begin
					a.cycles = dic_pkg::CYC_FOUR;
				end
			end
			dic_pkg::CLS_X: begin
				a.cycles = dic_pkg::CYC_FOUR;
				a.repeatable = 1'b0;
				a.mem = dic_pkg::MEM_PC;
			end
			dic_pkg::CLS_XI: begin
				a.cycles = dic_pkg::CYC_TWO;
				a.slots = dic_pkg::SLOTS_TWO;
				a.repeatable = 1'b0;
				a.mem = dic_pkg::MEM_PC;
			end
			dic_pkg::CLS_XII, dic_pkg::CLS_XIV: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_THREE;
				a.mem = dic_pkg::MEM_BLOCK;
			end
			dic_pkg::CLS_XIII, dic_pkg::CLS_XV, dic_pkg::CLS_XVI: begin
				a.cycles = dic_pkg::CYC_TWO;
				a.mem = dic_pkg::MEM_BLOCK;
			end
			dic_pkg::CLS_XVII, dic_pkg::CLS_XVIII: begin
				a.cycles = dic_pkg::CYC_THREE;
				a.mem = dic_pkg::MEM_TABLE;
			end
			dic_pkg::CLS_XIX, dic_pkg::CLS_XXI: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_THREE;
				a.mem = dic_pkg::MEM_READ;
			end
			dic_pkg::CLS_XX, dic_pkg::CLS_XXII: begin
				a.cycles = dic_pkg::CYC_TWO;
				a.mem = dic_pkg::MEM_READ;
			end
			dic_pkg::CLS_XXIII, dic_pkg::CLS_XXIV: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = dic_pkg::CYC_TWO;
				a.mem = (port_if.cls == dic_pkg::CLS_XXIII) ?
					dic_pkg::MEM_MMR_RD : dic_pkg::MEM_MMR_WR;
			end
			dic_pkg::CLS_XXV, dic_pkg::CLS_XXVI: begin
				a.words = dic_pkg::WORDS_TWO;
				a.cycles = (port_if.cls == dic_pkg::CLS_XXV) ?
					dic_pkg::CYC_THREE : dic_pkg::CYC_TWO;
				a.mem = dic_pkg::MEM_PORT;
			end
			dic_pkg::CLS_XXVII, dic_pkg::CLS_XXVIII: begin
				a.cycles = dic_pkg::CYC_TWO;
				a.protect = 1'b1;
				a.mem = dic_pkg::MEM_READ;
				a.repeatable = (port_if.cls == dic_pkg::CLS_XXVII);
			end
			dic_pkg::CLS_XXIX: begin
				a.cycles = dic_pkg::CYC_TWO;
				a.protect = 1'b1;
				a.repeatable = 1'b0;
			end
			default: begin
				a.mem = dic_pkg::MEM_NONE;
			end
		endcase
	end

	assign port_if.attr = a;
endmodule

// File: core/dic_classifier.sv
`timescale 1ns/1ps
// Summary of operation
// - No-operand forms: one word, one cycle
// - Listed short-immediate forms flagged not repeatable
// - Single memory-read forms: one word, one cycle
// - Mapped register read/store: one cycle
// - Long immediate: two words, two cycles
// - Single memory-write forms: one cycle
// - One-word read-modify-write: one cycle
// - Two-word read-modify-write, long compare: two cycles
// - Long immediate store: two cycles, not repeatable
// - Two-word plain branches/calls: four cycles, no slots
// - Two-word delayed branches/calls: two cycles, two slots
// - One-word plain discontinuities: four cycles, no slots
// - One-word delayed discontinuities: two cycles, two slots
// - Data block move: three or two cycles
// - Program block moves: three or two cycles
// - Table read and write: three cycles
// - Multiply-accumulate: three or two cycles
// - Multiply-accumulate with move: three or two cycles
// - Two-word mapped register load/store: two cycles
// - Output port three cycles, input two
// - Aux, page, status loads: two cycles, protected
// - Short repeat: two cycles, protected, not repeatable
// - Class chosen per syntax form, standalone timing
module dic_classifier (
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire logic decode_valid_i,
	input wire dic_pkg::dic_form_t form_i,
	output logic ready_o,
	output logic valid_o,
	output logic illegal_o,
	output dic_pkg::dic_class_t cls_o,
	output logic [1:0] words_o,
	output logic [2:0] cycles_o,
	output logic repeatable_o,
	output logic [1:0] slots_o,
	output logic protected_o,
	output dic_pkg::dic_mem_t mem_kind_o,
	output logic busy_o,
	output logic done_o,
	output logic slot_o
);
	// ****************************************************************
	// Form to class
	// ****************************************************************
	dic_pkg::dic_class_t form_cls;
	logic form_norep;
	logic form_ok;
	dic_pkg::dic_attr_t merged;
	dic_attr_if attr_if ();

	always_comb begin
		form_cls = dic_pkg::CLS_I;
		form_norep = 1'b0;
		form_ok = 1'b1;
		// One mnemonic can land in several classes
		case (form_i)
			dic_pkg::F_ABS_ACC, dic_pkg::F_ADD_BUF, dic_pkg::F_AND_BUF,
			dic_pkg::F_OR_BUF, dic_pkg::F_XOR_BUF, dic_pkg::F_SUB_BUF,
			dic_pkg::F_SHIFT_LEFT, dic_pkg::F_SHIFT_RIGHT,
			dic_pkg::F_ROT_LEFT, dic_pkg::F_ROT_RIGHT,
			dic_pkg::F_SET_FLAG, dic_pkg::F_CLEAR_FLAG,
			dic_pkg::F_NO_OP, dic_pkg::F_STACK_PUSH,
			dic_pkg::F_STACK_POP, dic_pkg::F_NEGATE,
			dic_pkg::F_NORMALIZE, dic_pkg::F_MODIFY_AUX: begin
				form_cls = dic_pkg::CLS_I;
			end
			// Idle cannot sit under a repeat
			dic_pkg::F_IDLE, dic_pkg::F_IDLE_LOW_POWER,
			dic_pkg::F_ADD_SHORT_IMM, dic_pkg::F_SUB_SHORT_IMM,
			dic_pkg::F_MULT_SHORT_IMM, dic_pkg::F_AUX_SHORT_ADD,
			dic_pkg::F_AUX_SHORT_SUB, dic_pkg::F_ACC_LOW_LOAD,
			dic_pkg::F_PRODUCT_SHIFT_SET,
			dic_pkg::F_CONDITIONAL_EXECUTE: begin
				form_cls = dic_pkg::CLS_I;
				form_norep = 1'b1;
			end
			dic_pkg::F_ADD_MEM, dic_pkg::F_SUB_MEM, dic_pkg::F_AND_MEM,
			dic_pkg::F_OR_MEM, dic_pkg::F_XOR_MEM, dic_pkg::F_BIT_TEST,
			dic_pkg::F_COMPARE_PARALLEL_LOGIC, dic_pkg::F_ACC_LOAD_MEM,
			dic_pkg::F_ACC_LOW_LOAD_MEM, dic_pkg::F_TEMP_LOAD,
			dic_pkg::F_MULT_MEM, dic_pkg::F_SQUARE_ADD,
			dic_pkg::F_SUB_COND, dic_pkg::F_DATA_PUSH: begin
				form_cls = dic_pkg::CLS_IIA;
			end
			dic_pkg::F_REPEAT_NEXT_MEM: begin
				form_cls = dic_pkg::CLS_IIA;
				form_norep = 1'b1;
			end
			dic_pkg::F_ACC_LOAD_FROM_MAPPED_REG: begin
				form_cls = dic_pkg::CLS_IIB;
			end
			dic_pkg::F_ACC_STORE_TO_MAPPED_REG: begin
				form_cls = dic_pkg::CLS_IVB;
			end
			dic_pkg::F_ADD_LONG_IMM, dic_pkg::F_AND_LONG_IMM,
			dic_pkg::F_OR_LONG_IMM, dic_pkg::F_XOR_LONG_IMM,
			dic_pkg::F_SUB_LONG_IMM, dic_pkg::F_ACC_LOAD_LONG_IMM,
			dic_pkg::F_AUX_LOAD_LONG_IMM, dic_pkg::F_MULT_LONG_IMM,
			dic_pkg::F_REPEAT_NEXT_LONG, dic_pkg::F_REPEAT_BLOCK,
			dic_pkg::F_REPEAT_WITH_CLEAR: begin
				form_cls = dic_pkg::CLS_III;
			end
			dic_pkg::F_DATA_POP, dic_pkg::F_STORE_ACC_HIGH,
			dic_pkg::F_STORE_ACC_LOW, dic_pkg::F_STORE_AUX,
			dic_pkg::F_STORE_PROD_HIGH, dic_pkg::F_STORE_PROD_LOW,
			dic_pkg::F_STORE_STATUS: begin
				form_cls = dic_pkg::CLS_IVA;
			end
			dic_pkg::F_AND_DBMR_MEMORY, dic_pkg::F_OR_DBMR_MEMORY,
			dic_pkg::F_XOR_DBMR_MEMORY, dic_pkg::F_DATA_MOVE_OP,
			dic_pkg::F_TEMP_LOAD_MOVE: begin
				form_cls = dic_pkg::CLS_V;
			end
			dic_pkg::F_AND_DBMR_MEMORY_LONG,
			dic_pkg::F_OR_DBMR_MEMORY_LONG,
			dic_pkg::F_XOR_DBMR_MEMORY_LONG: begin
				form_cls = dic_pkg::CLS_VI;
			end
			dic_pkg::F_COMPARE_PARALLEL_LOGIC_LONG: begin
				form_cls = dic_pkg::CLS_VIIA;
			end
			dic_pkg::F_STORE_LONG_IMMEDIATE: begin
				form_cls = dic_pkg::CLS_VIIB;
			end
			dic_pkg::F_BRANCH, dic_pkg::F_BRANCH_AUX_NONZERO,
			dic_pkg::F_BRANCH_CONDITIONAL, dic_pkg::F_CALL,
			dic_pkg::F_CALL_CONDITIONAL: begin
				form_cls = dic_pkg::CLS_VIII;
			end
			dic_pkg::F_BRANCH_DLY, dic_pkg::F_BRANCH_AUX_NONZERO_DLY,
			dic_pkg::F_BRANCH_CONDITIONAL_DLY, dic_pkg::F_CALL_DLY,
			dic_pkg::F_CALL_CONDITIONAL_DLY: begin
				form_cls = dic_pkg::CLS_IX;
			end
			dic_pkg::F_BRANCH_TO_ACC_ADDR, dic_pkg::F_CALL_TO_ACC_ADDR,
			dic_pkg::F_SOFTWARE_INTERRUPT, dic_pkg::F_NONMASKABLE_INT,
			dic_pkg::F_RETURN, dic_pkg::F_RETURN_CONDITIONAL,
			dic_pkg::F_RETURN_ENABLE_INT, dic_pkg::F_RETURN_FROM_INT,
			dic_pkg::F_TRAP: begin
				form_cls = dic_pkg::CLS_X;
			end
			dic_pkg::F_BRANCH_TO_ACC_ADDR_DLY,
			dic_pkg::F_CALL_TO_ACC_ADDR_DLY, dic_pkg::F_RETURN_DELAYED,
			dic_pkg::F_RETURN_COND_DELAYED: begin
				form_cls = dic_pkg::CLS_XI;
			end
			dic_pkg::F_BLOCK_MOVE_DATA_DATA_LONG: begin
				form_cls = dic_pkg::CLS_XII;
			end
			dic_pkg::F_BLOCK_MOVE_DATA_DATA: begin
				form_cls = dic_pkg::CLS_XIII;
			end
			dic_pkg::F_BLOCK_MOVE_PROG_DATA_LONG: begin
				form_cls = dic_pkg::CLS_XIV;
			end
			dic_pkg::F_BLOCK_MOVE_PROG_DATA: begin
				form_cls = dic_pkg::CLS_XV;
			end
			dic_pkg::F_BLOCK_MOVE_DATA_PROG: begin
				form_cls = dic_pkg::CLS_XVI;
			end
			dic_pkg::F_TABLE_READ_OP: begin
				form_cls = dic_pkg::CLS_XVII;
			end
			dic_pkg::F_TABLE_WRITE_OP: begin
				form_cls = dic_pkg::CLS_XVIII;
			end
			dic_pkg::F_MULT_ACCUM_TWO_WORD: begin
				form_cls = dic_pkg::CLS_XIX;
			end
			dic_pkg::F_MULT_ACCUM_DYN_ADDR: begin
				form_cls = dic_pkg::CLS_XX;
			end
			dic_pkg::F_MULT_ACCUM_MOVE_TWO_WORD: begin
				form_cls = dic_pkg::CLS_XXI;
			end
			dic_pkg::F_MULT_ACCUM_MOVE_DYN_ADDR: begin
				form_cls = dic_pkg::CLS_XXII;
			end
			dic_pkg::F_MAPPED_REG_LOAD_LONG: begin
				form_cls = dic_pkg::CLS_XXIII;
			end
			dic_pkg::F_MAPPED_REG_STORE_LONG: begin
				form_cls = dic_pkg::CLS_XXIV;
			end
			dic_pkg::F_PORT_OUT: begin
				form_cls = dic_pkg::CLS_XXV;
			end
			dic_pkg::F_PORT_IN: begin
				form_cls = dic_pkg::CLS_XXVI;
			end
			dic_pkg::F_AUX_REG_LOAD, dic_pkg::F_PAGE_POINTER_LOAD,
			dic_pkg::F_STATUS_LOAD: begin
				form_cls = dic_pkg::CLS_XXVII;
			end
			dic_pkg::F_AUX_REG_LOAD_IMM,
			dic_pkg::F_PAGE_POINTER_LOAD_IMM: begin
				form_cls = dic_pkg::CLS_XXVIII;
			end
			dic_pkg::F_REPEAT_NEXT_IMM: begin
				form_cls = dic_pkg::CLS_XXIX;
			end
			default: begin
				form_ok = 1'b0;
			end
		endcase
	end

	assign attr_if.cls = form_cls;

	dic_class_rom dic_class_rom_i (
		.port_if(attr_if)
	);

	always_comb begin
		merged = attr_if.attr;
		merged.repeatable = attr_if.attr.repeatable & ~form_norep;
	end

	// ****************************************************************
	// Issue and cycle sequencing
	// ****************************************************************
	dic_pkg::dic_state_t state_ff, nxt_state;
	dic_pkg::dic_class_t cls_ff, nxt_cls;
	dic_pkg::dic_attr_t attr_ff, nxt_attr;
	logic [2:0] cnt_ff, nxt_cnt;
	logic ready_ff, nxt_ready;
	logic valid_ff, nxt_valid;
	logic illegal_ff, nxt_illegal;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic slot_ff, nxt_slot;

	always_comb begin
		nxt_state = state_ff;
		nxt_cls = cls_ff;
		nxt_attr = attr_ff;
		nxt_cnt = cnt_ff;
		nxt_valid = 1'b0;
		nxt_illegal = illegal_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_slot = slot_ff;
		case (state_ff)
			dic_pkg::ST_IDLE: begin
				if (decode_valid_i) begin
					nxt_valid = 1'b1;
					nxt_illegal = ~form_ok;
					// Unknown forms leave the last good answer in place
					if (form_ok) begin
						nxt_cls = form_cls;
						nxt_attr = merged;
						nxt_cnt = merged.cycles - dic_pkg::CNT_ONE;
						nxt_busy = 1'b1;
						nxt_state = dic_pkg::ST_EXEC;
					end
				end
			end
			dic_pkg::ST_EXEC: begin
				if (cnt_ff == dic_pkg::CNT_ZERO) begin
					nxt_busy = 1'b0;
					nxt_done = 1'b1;
					if (attr_ff.slots != dic_pkg::SLOTS_NONE) begin
						nxt_cnt = {1'b0, attr_ff.slots} - dic_pkg::CNT_ONE;
						nxt_slot = 1'b1;
						nxt_state = dic_pkg::ST_SLOT;
					end else begin
						nxt_state = dic_pkg::ST_IDLE;
					end
				end else begin
					nxt_cnt = cnt_ff - dic_pkg::CNT_ONE;
				end
			end
			dic_pkg::ST_SLOT: begin
				if (cnt_ff == dic_pkg::CNT_ZERO) begin
					nxt_slot = 1'b0;
					nxt_state = dic_pkg::ST_IDLE;
				end else begin
					nxt_cnt = cnt_ff - dic_pkg::CNT_ONE;
				end
			end
			default: begin
				nxt_state = dic_pkg::ST_IDLE;
				nxt_cnt = dic_pkg::CNT_ZERO;
				nxt_busy = 1'b0;
				nxt_slot = 1'b0;
			end
		endcase
		nxt_ready = (nxt_state == dic_pkg::ST_IDLE);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!reset_n_i) begin
			state_ff <= dic_pkg::ST_IDLE;
			cls_ff <= dic_pkg::CLS_I;
			attr_ff <= dic_pkg::ATTR_RESET;
			cnt_ff <= dic_pkg::CNT_ZERO;
			ready_ff <= 1'b0;
			valid_ff <= 1'b0;
			illegal_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			slot_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			cls_ff <= nxt_cls;
			attr_ff <= nxt_attr;
			cnt_ff <= nxt_cnt;
			ready_ff <= nxt_ready;
			valid_ff <= nxt_valid;
			illegal_ff <= nxt_illegal;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			slot_ff <= nxt_slot;
		end
	end

	assign ready_o = ready_ff;
	assign valid_o = valid_ff;
	assign illegal_o = illegal_ff;
	assign cls_o = cls_ff;
	assign words_o = attr_ff.words;
	assign cycles_o = attr_ff.cycles;
	assign repeatable_o = attr_ff.repeatable;
	assign slots_o = attr_ff.slots;
	assign protected_o = attr_ff.protect;
	assign mem_kind_o = attr_ff.mem;
	assign busy_o = busy_ff;
	assign done_o = done_ff;
	assign slot_o = slot_ff;
endmodule

// File: core/dic_pkg.sv
package dic_pkg;

	// ****************************************************************
	// Cycle classes
	// ****************************************************************
	typedef enum logic [4:0] {
		CLS_I = 5'h00, CLS_IIA = 5'h01, CLS_IIB = 5'h02,
		CLS_III = 5'h03, CLS_IVA = 5'h04, CLS_IVB = 5'h05,
		CLS_V = 5'h06, CLS_VI = 5'h07, CLS_VIIA = 5'h08,
		CLS_VIIB = 5'h09, CLS_VIII = 5'h0A, CLS_IX = 5'h0B,
		CLS_X = 5'h0C, CLS_XI = 5'h0D, CLS_XII = 5'h0E,
		CLS_XIII = 5'h0F, CLS_XIV = 5'h10, CLS_XV = 5'h11,
		CLS_XVI = 5'h12, CLS_XVII = 5'h13, CLS_XVIII = 5'h14,
		CLS_XIX = 5'h15, CLS_XX = 5'h16, CLS_XXI = 5'h17,
		CLS_XXII = 5'h18, CLS_XXIII = 5'h19, CLS_XXIV = 5'h1A,
		CLS_XXV = 5'h1B, CLS_XXVI = 5'h1C, CLS_XXVII = 5'h1D,
		CLS_XXVIII = 5'h1E, CLS_XXIX = 5'h1F
	} dic_class_t;

	typedef enum logic [3:0] {
		MEM_NONE = 4'h0, MEM_READ = 4'h1, MEM_WRITE = 4'h2,
		MEM_RMW = 4'h3, MEM_MMR_RD = 4'h4, MEM_MMR_WR = 4'h5,
		MEM_BLOCK = 4'h6, MEM_TABLE = 4'h7, MEM_PORT = 4'h8,
		MEM_PC = 4'h9
	} dic_mem_t;

	typedef struct packed {
		logic [1:0] words;
		logic [2:0] cycles;
		logic repeatable;
		logic [1:0] slots;
		logic protect;
		dic_mem_t mem;
	} dic_attr_t;

	// ****************************************************************
	// Field values and reset values
	// ****************************************************************
	localparam logic [1:0] WORDS_ONE = 2'h1;
	localparam logic [1:0] WORDS_TWO = 2'h2;
	localparam logic [2:0] CYC_ONE = 3'h1;
	localparam logic [2:0] CYC_TWO = 3'h2;
	localparam logic [2:0] CYC_THREE = 3'h3;
	localparam logic [2:0] CYC_FOUR = 3'h4;
	localparam logic [1:0] SLOTS_NONE = 2'h0;
	localparam logic [1:0] SLOTS_TWO = 2'h2;
	localparam logic [2:0] CNT_ZERO = 3'h0;
	localparam logic [2:0] CNT_ONE = 3'h1;
	localparam dic_attr_t ATTR_RESET = '{2'h0, 3'h0, 1'b0, 2'h0,
		1'b0, MEM_NONE};

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_EXEC = 3'h2,
		ST_SLOT = 3'h4
	} dic_state_t;

	// ****************************************************************
	// Decoded instruction forms
	// ****************************************************************
	typedef enum logic [6:0] {
		F_ABS_ACC, F_ADD_BUF, F_AND_BUF, F_OR_BUF, F_XOR_BUF,
		F_SUB_BUF, F_SHIFT_LEFT, F_SHIFT_RIGHT, F_ROT_LEFT,
		F_ROT_RIGHT, F_SET_FLAG, F_CLEAR_FLAG, F_IDLE,
		F_IDLE_LOW_POWER, F_NO_OP, F_STACK_PUSH, F_STACK_POP,
		F_NEGATE, F_NORMALIZE, F_MODIFY_AUX,
		F_ADD_SHORT_IMM, F_SUB_SHORT_IMM, F_MULT_SHORT_IMM,
		F_AUX_SHORT_ADD, F_AUX_SHORT_SUB, F_ACC_LOW_LOAD,
		F_PRODUCT_SHIFT_SET, F_CONDITIONAL_EXECUTE,
		F_ADD_MEM, F_SUB_MEM, F_AND_MEM, F_OR_MEM, F_XOR_MEM,
		F_BIT_TEST, F_COMPARE_PARALLEL_LOGIC, F_ACC_LOAD_MEM,
		F_ACC_LOW_LOAD_MEM, F_TEMP_LOAD, F_MULT_MEM, F_SQUARE_ADD,
		F_SUB_COND, F_DATA_PUSH, F_REPEAT_NEXT_MEM,
		F_ACC_LOAD_FROM_MAPPED_REG, F_ACC_STORE_TO_MAPPED_REG,
		F_ADD_LONG_IMM, F_AND_LONG_IMM, F_OR_LONG_IMM,
		F_XOR_LONG_IMM, F_SUB_LONG_IMM, F_ACC_LOAD_LONG_IMM,
		F_AUX_LOAD_LONG_IMM, F_MULT_LONG_IMM, F_REPEAT_NEXT_LONG,
		F_REPEAT_BLOCK, F_REPEAT_WITH_CLEAR,
		F_DATA_POP, F_STORE_ACC_HIGH, F_STORE_ACC_LOW, F_STORE_AUX,
		F_STORE_PROD_HIGH, F_STORE_PROD_LOW, F_STORE_STATUS,
		F_AND_DBMR_MEMORY, F_OR_DBMR_MEMORY, F_XOR_DBMR_MEMORY,
		F_DATA_MOVE_OP, F_TEMP_LOAD_MOVE,
		F_AND_DBMR_MEMORY_LONG, F_OR_DBMR_MEMORY_LONG,
		F_XOR_DBMR_MEMORY_LONG, F_COMPARE_PARALLEL_LOGIC_LONG,
		F_STORE_LONG_IMMEDIATE,
		F_BRANCH, F_BRANCH_AUX_NONZERO, F_BRANCH_CONDITIONAL,
		F_CALL, F_CALL_CONDITIONAL,
		F_BRANCH_DLY, F_BRANCH_AUX_NONZERO_DLY,
		F_BRANCH_CONDITIONAL_DLY, F_CALL_DLY, F_CALL_CONDITIONAL_DLY,
		F_BRANCH_TO_ACC_ADDR, F_CALL_TO_ACC_ADDR,
		F_SOFTWARE_INTERRUPT, F_NONMASKABLE_INT, F_RETURN,
		F_RETURN_CONDITIONAL, F_RETURN_ENABLE_INT, F_RETURN_FROM_INT,
		F_TRAP,
		F_BRANCH_TO_ACC_ADDR_DLY, F_CALL_TO_ACC_ADDR_DLY,
		F_RETURN_DELAYED, F_RETURN_COND_DELAYED,
		F_BLOCK_MOVE_DATA_DATA_LONG, F_BLOCK_MOVE_DATA_DATA,
		F_BLOCK_MOVE_PROG_DATA_LONG, F_BLOCK_MOVE_PROG_DATA,
		F_BLOCK_MOVE_DATA_PROG, F_TABLE_READ_OP, F_TABLE_WRITE_OP,
		F_MULT_ACCUM_TWO_WORD, F_MULT_ACCUM_DYN_ADDR,
		F_MULT_ACCUM_MOVE_TWO_WORD, F_MULT_ACCUM_MOVE_DYN_ADDR,
		F_MAPPED_REG_LOAD_LONG, F_MAPPED_REG_STORE_LONG,
		F_PORT_OUT, F_PORT_IN,
		F_AUX_REG_LOAD, F_PAGE_POINTER_LOAD, F_STATUS_LOAD,
		F_AUX_REG_LOAD_IMM, F_PAGE_POINTER_LOAD_IMM,
		F_REPEAT_NEXT_IMM
	} dic_form_t;

endpackage
